// ==== lda_fault_mon.sv ====
// Laser pin fault detector with periodic self-test.
`timescale 1ns/10ps
`default_nettype none
module lda_fault_mon (
  input  wire logic ref_clk,
  input  wire logic resetn,
  input  wire logic pin_ground,
  output var  logic test_active_q,
  output var  logic test_pull_q,
  output var  logic fault_q
);

  lda_pkg::lda_test_state_t state_q;
  logic [15:0]              period_cnt_q;
  logic [7:0]               settle_cnt_q;
  logic                     period_done;
  logic                     pull_tail_q;
  logic                     ground_seen;

  assign period_done = (period_cnt_q == 16'(lda_pkg::TEST_PERIOD_CYC - 1));

  // Own pull lingers on the pin one cycle after a test; not a short
  assign ground_seen = pin_ground && !pull_tail_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pull_tail_q <= 1'b0;
    end else begin
      pull_tail_q <= test_pull_q;
    end
  end

  // Period divider that launches a test
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      period_cnt_q <= 16'h0000;
    end else if (period_done) begin
      period_cnt_q <= 16'h0000;
    end else begin
      period_cnt_q <= period_cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q      <= lda_pkg::ST_IDLE;
      settle_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        lda_pkg::ST_IDLE: begin
          settle_cnt_q <= 8'h00;
          if (ground_seen) begin
            state_q <= lda_pkg::ST_FAULT;
          end else if (period_done) begin
            state_q <= lda_pkg::ST_PULL;
          end
        end
        lda_pkg::ST_PULL: begin
          settle_cnt_q <= settle_cnt_q + 8'h01;
          if (settle_cnt_q == 8'(lda_pkg::TEST_SETTLE_CYC - 1)) begin
            state_q <= lda_pkg::ST_CHECK;
          end
        end
        lda_pkg::ST_CHECK: begin
          // Pin must follow the internal pull; a pin held high is a short
          if (pin_ground) begin
            state_q <= lda_pkg::ST_IDLE;
          end else begin
            state_q <= lda_pkg::ST_FAULT;
          end
        end
        lda_pkg::ST_FAULT: begin
          state_q <= lda_pkg::ST_FAULT;
        end
        default: begin
          state_q <= lda_pkg::ST_FAULT;
        end
      endcase
    end
  end

  // Registered view of the state
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      test_active_q <= 1'b0;
      test_pull_q   <= 1'b0;
      fault_q       <= 1'b0;
    end else begin
      test_active_q <= (state_q == lda_pkg::ST_IDLE && !ground_seen && period_done) ||
                       (state_q == lda_pkg::ST_PULL) ||
                       (state_q == lda_pkg::ST_CHECK && pin_ground);
      test_pull_q   <= (state_q == lda_pkg::ST_IDLE && !ground_seen && period_done) ||
                       (state_q == lda_pkg::ST_PULL);
      fault_q       <= (state_q == lda_pkg::ST_FAULT) ||
                       (state_q == lda_pkg::ST_IDLE && ground_seen) ||
                       (state_q == lda_pkg::ST_CHECK && !pin_ground);
    end
  end

endmodule : lda_fault_mon
`default_nettype wire

// ==== lda_laser_drive.sv ====
// Laser drive control: settings registers, drive shaping and fault shutdown.
// Notes on behaviour
// - Drive laser in pulses normally; drive continuously in calibration mode.
// - Setup bit 7 picks current range; zero low, one high.
// - Inverse setup bit 7 holds complement of range bit; host writes it.
// - Setup bit 5 is bin match bit, written by host for fitted laser.
// - Inverse setup bit 5 holds complement of bin match bit.
// - Calibration code in setup bits 3..1 gives full duty cycle drive.
// - Eight-bit current level with inverse partner; zero gives minimum current.
// - Settings are not kept over reset; host restores them afterward.
// - Ground path on drive pin stops current and raises enable-low output.
// - Periodic self-test pulls pin low with laser off; failure reports fault.
`timescale 1ns/10ps
`default_nettype none
module lda_laser_drive (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata_q,
  output var  logic       reg_rvalid_q,
  input  wire logic       laser_pin_ground,
  output var  logic       laser_drive_on_q,
  output var  logic [7:0] laser_current_q,
  output var  logic       laser_range_high_q,
  output var  logic       laser_cw_q,
  output var  logic       laser_enable_low_q,
  output var  logic       laser_test_pull_q,
  output var  logic       laser_fault_q
);

  // Address decode shared by write and read paths
  function automatic logic [4:0] lda_decode(input logic [7:0] addr);
    logic [4:0] sel;
    sel = 5'h00;
    case (addr)
      lda_pkg::SETUP_OFFSET:     sel = 5'h01;
      lda_pkg::LEVEL_OFFSET:     sel = 5'h02;
      lda_pkg::LEVEL_INV_OFFSET: sel = 5'h04;
      lda_pkg::SETUP_INV_OFFSET: sel = 5'h08;
      lda_pkg::STATUS_OFFSET:    sel = 5'h10;
      default:                   sel = 5'h00;
    endcase
    return sel;
  endfunction : lda_decode

  // True when the field and its partner are exact complements
  function automatic logic lda_pair_ok(input logic [7:0] a, input logic [7:0] b, input logic [7:0] mask);
    return ((a ^ b) & mask) == mask;
  endfunction : lda_pair_ok

  localparam logic [7:0] RANGE_MASK = 8'h01 << lda_pkg::RANGE_BIT;
  localparam logic [7:0] MATCH_MASK = 8'h01 << lda_pkg::MATCH_BIT;
  localparam logic [7:0] MODE_MASK  = 8'h0E;
  localparam logic [7:0] FULL_MASK  = 8'hFF;

  logic [7:0]  setup_q;
  logic [7:0]  setup_inv_q;
  logic [7:0]  level_q;
  logic [7:0]  level_inv_q;
  logic [4:0]  wr_sel;
  logic [4:0]  rd_sel;
  logic        range_ok;
  logic        match_ok;
  logic        mode_ok;
  logic        level_ok;
  logic        settings_valid;
  logic        cal_mode;
  logic [7:0]  pulse_cnt_q;
  logic        pulse_phase;
  logic        test_active;
  logic        test_pull;
  logic        fault;
  logic [7:0]  status_word;

  assign wr_sel = lda_decode(reg_addr);
  assign rd_sel = lda_decode(reg_addr);

  // Setup register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      setup_q <= lda_pkg::SETUP_RESET;
    end else if (reg_wr && wr_sel[0]) begin
      setup_q <= reg_wdata;
    end
  end

  // Inverse setup register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      setup_inv_q <= lda_pkg::SETUP_INV_RESET;
    end else if (reg_wr && wr_sel[3]) begin
      setup_inv_q <= reg_wdata;
    end
  end

  // Current level register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      level_q <= lda_pkg::LEVEL_RESET;
    end else if (reg_wr && wr_sel[1]) begin
      level_q <= reg_wdata;
    end
  end

  // Inverse current level register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      level_inv_q <= lda_pkg::LEVEL_INV_RESET;
    end else if (reg_wr && wr_sel[2]) begin
      level_inv_q <= reg_wdata;
    end
  end

  // Pair checks gate the drive, current, range and continuous outputs; enable-low and test pull ignore them
  assign range_ok       = lda_pair_ok(setup_q, setup_inv_q, RANGE_MASK);
  assign match_ok       = lda_pair_ok(setup_q, setup_inv_q, MATCH_MASK);
  assign mode_ok        = lda_pair_ok(setup_q, setup_inv_q, MODE_MASK);
  assign level_ok       = lda_pair_ok(level_q, level_inv_q, FULL_MASK);
  assign settings_valid = range_ok && match_ok && mode_ok && level_ok;

  assign cal_mode = (setup_q[lda_pkg::MODE_MSB:lda_pkg::MODE_LSB] == lda_pkg::CAL_MODE_CODE);

  // Pulse divider for normal drive
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_cnt_q <= 8'h00;
    end else if (pulse_cnt_q == 8'(lda_pkg::PULSE_PERIOD_CYC - 1)) begin
      pulse_cnt_q <= 8'h00;
    end else begin
      pulse_cnt_q <= pulse_cnt_q + 8'h01;
    end
  end

  assign pulse_phase = (pulse_cnt_q < 8'(lda_pkg::PULSE_ON_CYC));

  // Fault detection and self-test
  lda_fault_mon u_fault_mon (
    .ref_clk       (ref_clk),
    .resetn        (resetn),
    .pin_ground    (laser_pin_ground),
    .test_active_q (test_active),
    .test_pull_q   (test_pull),
    .fault_q       (fault)
  );

  // Drive outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      laser_drive_on_q   <= 1'b0;
      laser_current_q    <= 8'h00;
      laser_range_high_q <= 1'b0;
      laser_cw_q         <= 1'b0;
    end else if (fault || test_active || !settings_valid) begin
      laser_drive_on_q   <= 1'b0;
      laser_current_q    <= 8'h00;
      laser_range_high_q <= 1'b0;
      laser_cw_q         <= 1'b0;
    end else begin
      laser_drive_on_q   <= cal_mode || pulse_phase;
      laser_current_q    <= level_q;
      laser_range_high_q <= setup_q[lda_pkg::RANGE_BIT];
      laser_cw_q         <= cal_mode;
    end
  end

  // Enable-low output and self-test pull
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      laser_enable_low_q <= 1'b1;
      laser_test_pull_q  <= 1'b0;
      laser_fault_q      <= 1'b0;
    end else begin
      laser_enable_low_q <= fault || test_active;
      laser_test_pull_q  <= test_pull;
      laser_fault_q      <= fault;
    end
  end

  always_comb begin
    status_word                    = 8'h00;
    status_word[lda_pkg::STAT_FAULT] = fault;
    status_word[lda_pkg::STAT_VALID] = settings_valid;
    status_word[lda_pkg::STAT_CW]    = laser_cw_q;
    status_word[lda_pkg::STAT_TEST]  = test_active;
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q  <= 8'h00;
      reg_rvalid_q <= 1'b0;
    end else begin
      reg_rvalid_q <= reg_rd;
      if (reg_rd) begin
        case (rd_sel)
          5'h01:   reg_rdata_q <= setup_q;
          5'h02:   reg_rdata_q <= level_q;
          5'h04:   reg_rdata_q <= level_inv_q;
          5'h08:   reg_rdata_q <= setup_inv_q;
          5'h10:   reg_rdata_q <= status_word;
          default: reg_rdata_q <= 8'h00;
        endcase
      end
    end
  end

endmodule : lda_laser_drive
`default_nettype wire

// ==== lda_laser_drive_properties.sv ====
// Port checks for the laser drive control block.
`timescale 1ns/10ps
`default_nettype none
module lda_laser_drive_properties (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       reg_rvalid_q,
  input wire logic       laser_pin_ground,
  input wire logic       laser_drive_on_q,
  input wire logic [7:0] laser_current_q,
  input wire logic       laser_range_high_q,
  input wire logic       laser_cw_q,
  input wire logic       laser_enable_low_q,
  input wire logic       laser_test_pull_q,
  input wire logic       laser_fault_q
);
  logic [7:0] on_run_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // Length of the current pulse
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) on_run_q <= 8'h00;
    else if (laser_drive_on_q && !laser_cw_q) on_run_q <= on_run_q + 8'h01;
    else on_run_q <= 8'h00;
  end
  a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
    else $error("read not answered");
  a_rvalid_cause: assert property (reg_rvalid_q |-> $past(reg_rd))
    else $error("read answer without request");
  a_pulse_width: assert property (on_run_q <= 8'(lda_pkg::PULSE_ON_CYC))
    else $error("pulse too long");
  a_cw_steady: assert property (laser_cw_q |-> laser_drive_on_q)
    else $error("continuous drive gap");
  a_fault_sticky: assert property (laser_fault_q |=> laser_fault_q)
    else $error("fault cleared");
  a_fault_off: assert property (laser_fault_q |-> laser_enable_low_q && !laser_drive_on_q && laser_current_q == 8'h00)
    else $error("laser on under fault");
  a_fault_modes: assert property (laser_fault_q |-> !laser_cw_q && !laser_range_high_q)
    else $error("modes kept under fault");
  a_ground_trips: assert property ($rose(laser_pin_ground) && !laser_test_pull_q |-> ##[1:3] laser_fault_q)
    else $error("ground short not caught");
  a_test_dark: assert property (laser_test_pull_q [*3] |-> laser_enable_low_q && !laser_drive_on_q)
    else $error("laser on during self test");
  a_write_readback: assert property ((reg_wr && !reg_rd && (reg_addr == lda_pkg::SETUP_OFFSET ||
    reg_addr == lda_pkg::SETUP_INV_OFFSET || reg_addr == lda_pkg::LEVEL_OFFSET ||
    reg_addr == lda_pkg::LEVEL_INV_OFFSET)) ##1 !reg_wr ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2))
    |=> reg_rdata_q == $past(reg_wdata, 3))
    else $error("register read back differs from write");
  c_cw: cover property (laser_cw_q);
  c_pulse: cover property ($rose(laser_drive_on_q) && !laser_cw_q);
  c_fault: cover property ($rose(laser_fault_q));
endmodule : lda_laser_drive_properties
bind lda_laser_drive lda_laser_drive_properties u_props (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .laser_pin_ground(laser_pin_ground), .laser_drive_on_q(laser_drive_on_q), .laser_current_q(laser_current_q),
  .laser_range_high_q(laser_range_high_q), .laser_cw_q(laser_cw_q), .laser_enable_low_q(laser_enable_low_q),
  .laser_test_pull_q(laser_test_pull_q), .laser_fault_q(laser_fault_q));
`default_nettype wire

// ==== lda_laser_drive_tb.sv ====
// Self-checking bench for the laser drive control block.
`timescale 1ns/10ps
`default_nettype none
module lda_laser_drive_tb;
  logic       ref_clk, resetn, reg_wr, reg_rd, rvalid, pin_ground, short_gnd, short_vdd;
  logic       drive_on, range_high, cw, enable_low, test_pull, fault;
  logic [7:0] reg_addr, reg_wdata, rdata, current, cal;
  int         num_errors, num_checks, cnt;
  lda_laser_drive u_lda_laser_drive (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .reg_rvalid_q(rvalid),
    .laser_pin_ground(pin_ground), .laser_drive_on_q(drive_on), .laser_current_q(current),
    .laser_range_high_q(range_high), .laser_cw_q(cw), .laser_enable_low_q(enable_low),
    .laser_test_pull_q(test_pull), .laser_fault_q(fault));
  lda_pin_model u_lda_pin_model (.test_pull(test_pull), .short_gnd(short_gnd), .short_vdd(short_vdd),
    .pin_ground(pin_ground));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(8'(rvalid), 8'h01);
    chk(rdata, exp);
  endtask : rd
  task pair(input logic [7:0] s, input logic [7:0] l);
    wr(lda_pkg::SETUP_OFFSET, s);
    wr(lda_pkg::SETUP_INV_OFFSET, ~s);
    wr(lda_pkg::LEVEL_OFFSET, l);
    wr(lda_pkg::LEVEL_INV_OFFSET, ~l);
  endtask : pair
  task count(input int n);
    cnt = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      cnt += int'(drive_on);
    end
  endtask : count
  task settle;
    repeat (2) @(posedge ref_clk);
    #1;
    for (int i = 0; i < 300 && drive_on !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
  endtask : settle
  task results;
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  initial begin
    repeat (10000) @(posedge ref_clk);
    num_errors++;
    results();
  end
  initial begin
    resetn = 1'b0;
    {reg_wr, reg_rd, short_gnd, short_vdd} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    num_errors = 0;
    num_checks = 0;
    cal = {4'h0, lda_pkg::CAL_MODE_CODE, 1'b0};
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(lda_pkg::SETUP_OFFSET, 8'h00);
    rd(lda_pkg::LEVEL_INV_OFFSET, 8'h00);
    rd(8'h20, 8'h00);
    count(250);
    chk(8'(cnt), 8'h00);
    pair(8'h20, 8'h40);
    settle();
    chk(current, 8'h40);
    chk(8'(range_high), 8'h00);
    count(lda_pkg::PULSE_PERIOD_CYC);
    chk(8'(cnt), 8'(lda_pkg::PULSE_ON_CYC));
    rd(lda_pkg::SETUP_INV_OFFSET, 8'hDF);
    wr(lda_pkg::SETUP_INV_OFFSET, 8'h5F);
    rd(lda_pkg::SETUP_INV_OFFSET, 8'h5F);
    count(250);
    chk(8'(cnt), 8'h00);
    pair(8'h20 | cal, 8'h00);
    settle();
    chk(8'({cw, drive_on}), 8'h03);
    chk(current, 8'h00);
    for (int l = 1; l < 256; l += 127) begin
      wr(lda_pkg::LEVEL_OFFSET, 8'(l));
      wr(lda_pkg::LEVEL_INV_OFFSET, ~8'(l));
      settle();
      chk(current, 8'(l));
    end
    pair(8'hA0 | cal, 8'h80);
    settle();
    chk(8'({range_high, cw}), 8'h03);
    chk(current, 8'h80);
    @(posedge ref_clk);
    short_gnd <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(8'({fault, enable_low, drive_on, cw}), 8'h0C);
    @(posedge ref_clk);
    short_gnd <= 1'b0;
    count(20);
    chk(8'(fault), 8'h01);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd(lda_pkg::SETUP_OFFSET, 8'h00);
    chk(8'(fault), 8'h00);
    chk(8'({enable_low, test_pull}), 8'h00);
    pair(8'hA0 | cal, 8'h10);
    count(1100);
    chk(8'(fault), 8'h00);
    chk(8'(cnt > 1080 && cnt < 1100), 8'h01);
    @(posedge ref_clk);
    short_vdd <= 1'b1;
    for (int i = 0; i < 1200 && fault !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(8'({fault, drive_on}), 8'h02);
    results();
  end
endmodule : lda_laser_drive_tb
`default_nettype wire

// ==== lda_pin_model.sv ====
// Laser drive pin model: healthy pull, ground short, supply short.
`timescale 1ns/10ps
`default_nettype none
module lda_pin_model (
  input  wire logic test_pull,
  input  wire logic short_gnd,
  input  wire logic short_vdd,
  output var  logic pin_ground
);
  // Pin follows the self-test pull unless shorted to ground or tied to supply
  always_comb pin_ground = short_gnd | (test_pull & ~short_vdd);
endmodule : lda_pin_model
`default_nettype wire

// ==== lda_pkg.sv ====
// Shared constants for the laser drive control block.
`default_nettype none
package lda_pkg;
  // Register offsets
  localparam logic [7:0] SETUP_OFFSET      = 8'h1A;
  localparam logic [7:0] LEVEL_OFFSET      = 8'h1C;
  localparam logic [7:0] LEVEL_INV_OFFSET  = 8'h1D;
  localparam logic [7:0] SETUP_INV_OFFSET  = 8'h1F;
  localparam logic [7:0] STATUS_OFFSET     = 8'h3F;

  // Field positions in the setup pair
  localparam int RANGE_BIT     = 7;
  localparam int MATCH_BIT     = 5;
  localparam int MODE_LSB      = 1;
  localparam int MODE_MSB      = 3;

  // Mode code that selects continuous drive
  localparam logic [2:0] CAL_MODE_CODE = 3'h5;

  // Status register bit positions
  localparam int STAT_FAULT    = 0;
  localparam int STAT_VALID    = 1;
  localparam int STAT_CW       = 2;
  localparam int STAT_TEST     = 3;

  // Reset values: nothing is retained, all pairs start mismatched
  localparam logic [7:0] SETUP_RESET      = 8'h00;
  localparam logic [7:0] SETUP_INV_RESET  = 8'h00;
  localparam logic [7:0] LEVEL_RESET      = 8'h00;
  localparam logic [7:0] LEVEL_INV_RESET  = 8'h00;

  // Timing
  localparam int CLK_MHZ           = 25;
  localparam int PULSE_PERIOD_NS   = 8000;
  localparam int PULSE_ON_NS       = 2000;
  localparam int TEST_PERIOD_NS    = 40000;
  localparam int TEST_SETTLE_NS    = 160;
  localparam int PULSE_PERIOD_CYC  = (PULSE_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int PULSE_ON_CYC      = (PULSE_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int TEST_PERIOD_CYC   = (TEST_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int TEST_SETTLE_CYC   = (TEST_SETTLE_NS * CLK_MHZ + 999) / 1000;

  // Self-test states, Gray along idle, pull, check
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_PULL  = 2'b01,
    ST_CHECK = 2'b11,
    ST_FAULT = 2'b10
  } lda_test_state_t;
endpackage : lda_pkg
`default_nettype wire
